// ==== design/pslave_pkg.sv ====
/*
  constants, reset values and state encoding shared by the parallel slave port files.
  assumes a single 25 MHz ref_clk domain; no timing constants are needed here.
*/
package pslave_pkg;

  // widths and depths
  localparam int DATA_W      = 8;
  localparam int FIFO_DEPTH  = 16;
  localparam int STATUS_W    = 7;
  localparam int DELAY_W     = 3;
  localparam int CTRL_SYNC_W = 4;

  // field positions of the host status byte
  localparam int HOST_BUSY_POS = 7;

  // address select decode
  localparam logic ADDR_DATA   = 1'b0;
  localparam logic ADDR_STATUS = 1'b1;

  // values after reset
  localparam logic [DATA_W-1:0]      DATA_RST       = 8'h00;
  localparam logic [STATUS_W-1:0]    STATUS_RST     = 7'h00;
  localparam logic [DELAY_W-1:0]     DELAY_CNT_RST  = 3'h0;
  localparam logic                   EMPTY_RST      = 1'b1;
  localparam logic                   BUSY_RST       = 1'b0;
  localparam logic                   OVER_UNDER_RST = 1'b0;
  localparam logic                   READY_RST      = 1'b0;
  // synchronised control pins {cs_n, rd_n, wr_n, addr} idle values
  localparam logic [CTRL_SYNC_W-1:0] CTRL_IDLE      = 4'hE;

  // host cycle tracker, gray coded along idle -> wait -> hold
  typedef enum logic [1:0] {
    CYC_IDLE    = 2'b00,
    CYC_WR_WAIT = 2'b01,
    CYC_WR_HOLD = 2'b11,
    CYC_RD_HOLD = 2'b10
  } host_cycle_e;

endpackage : pslave_pkg

// ==== design/pin_filter.sv ====
/*
  three flip-flop synchroniser with an agreement filter for pins from outside ref_clk.
  assumes the pins change slowly compared to ref_clk; a change counts once the second
  and third stage agree.
*/
`timescale 1ns/100ps
`default_nettype none

module pin_filter #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] RST   = '0
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // pins and filtered value
  input  wire logic [WIDTH-1:0] pin_in,
  output var  logic [WIDTH-1:0] filt_reg
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stage1_reg <= RST;
      stage2_reg <= RST;
      stage3_reg <= RST;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      filt_reg <= RST;
    end else if (stage2_reg == stage3_reg) begin
      filt_reg <= stage3_reg;
    end
  end

endmodule : pin_filter

`default_nettype wire

// ==== design/byte_fifo.sv ====
/*
  synchronous first-word-fall-through fifo with valid/ready on both sides.
  assumes one clock; full and empty come from registered occupancy count.
*/
`timescale 1ns/100ps
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule : byte_fifo

`default_nettype wire

// ==== design/parallel_slave_port.sv ====
/*
  parallel slave port: asynchronous 8-bit host bus with one address select, read and
  write strobes and chip select, buffered through a 16-byte fifo toward the cpu or
  the data-flow channel, with busy handshake, write sampling delay, overrun/underrun
  detection and an interrupt request.
  assumes host pins are asynchronous to ref_clk and held for several ref_clk periods;
  cpu control bits arrive as plain ports synchronous to ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none

// Function
// - 8-bit bus, one address line, 16-byte fifo
// - inactive until the enable bit is set
// - enabled: pins input, pull-ups off
// - status read returns host status byte
// - write with select high enters fifo
// - data read delivers next fifo byte
// - data write enters fifo for cpu/channel
// - write data sampled 0-7 clocks after strobe
// - host byte written with select high sets busy flag
// - software clearing busy clears host copy
// - software loads host status value
// - firmware polls fifo empty before reading
// - cpu transfers byte-wise with software pacing
// - channel mode: busy clears once peer ready
// - full write or empty read sets flag
// - overrun discards the written byte
// - underrun repeats the previous read byte
// - enabled flags raise interrupt when globally enabled
// - empty flag follows fifo occupancy
// - overrun/underrun flag held until software clears
// - status byte: busy in bit 7
// - ready flag set on data, cleared after read
module parallel_slave_port
  import pslave_pkg::*;
#(
  parameter int FIFO_W = pslave_pkg::DATA_W,
  parameter int FIFO_D = pslave_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           reset,
  // host pins
  input  wire logic                           host_cs_n,
  input  wire logic                           host_read_strobe_n,
  input  wire logic                           host_write_strobe_n,
  input  wire logic                           host_addr_select,
  input  wire logic [pslave_pkg::DATA_W-1:0]  host_data_in,
  output logic      [pslave_pkg::DATA_W-1:0]  host_data_out,
  output logic                                host_data_oe_n,
  // pin configuration
  output logic                                pin_input_mode,
  output logic                                pin_pullup_on,
  // control bits
  input  wire logic                           port_enable_bit,
  input  wire logic                           busy_irq_enable,
  input  wire logic                           over_under_irq_enable,
  input  wire logic                           port_global_irq_enable,
  input  wire logic [pslave_pkg::DELAY_W-1:0] write_sample_delay,
  input  wire logic                           service_by_channel,
  input  wire logic                           dir_to_host,
  // software commands
  input  wire logic                           busy_set,
  input  wire logic                           busy_clear,
  input  wire logic                           over_under_clear,
  input  wire logic                           host_status_wr,
  input  wire logic [pslave_pkg::STATUS_W-1:0] host_status_wdata,
  input  wire logic                           channel_peer_ready,
  // status
  output logic                                fifo_empty_flag,
  output logic                                processing_busy_flag,
  output logic                                over_under_flag,
  output logic                                host_data_ready_flag,
  output logic      [pslave_pkg::STATUS_W-1:0] host_status_value,
  output logic                                irq,
  // device-side fill (cpu or channel toward host)
  input  wire logic                           dev_in_valid,
  input  wire logic [pslave_pkg::DATA_W-1:0]  dev_in_data,
  output logic                                dev_in_ready,
  // device-side drain (host toward cpu or channel)
  output logic                                dev_out_valid,
  output logic      [pslave_pkg::DATA_W-1:0]  dev_out_data,
  input  wire logic                           dev_out_ready
);

  import pslave_pkg::*;

  logic [CTRL_SYNC_W-1:0] ctrl_f;
  logic [DATA_W-1:0]      data_f;
  logic                   cs_n_f;
  logic                   rd_n_f;
  logic                   wr_n_f;
  logic                   addr_f;
  logic                   rd_n_q_reg;
  logic                   wr_n_q_reg;
  host_cycle_e            state_reg;
  host_cycle_e            state_next;
  logic [DELAY_W-1:0]     delay_cnt_reg;
  logic                   wr_addr_reg;
  logic                   push_addr;
  logic                   wr_start;
  logic                   rd_start;
  logic                   rd_end;
  logic                   sample_now;
  logic                   host_push;
  logic                   host_overrun;
  logic                   host_pop;
  logic                   host_underrun;
  logic [DATA_W-1:0]      rd_data_reg;
  logic [DATA_W-1:0]      last_byte_reg;
  logic                   busy_reg;
  logic                   clear_pending_reg;
  logic                   over_under_reg;
  logic                   empty_reg;
  logic                   ready_reg;
  logic [STATUS_W-1:0]    status_reg;
  logic                   oe_n_reg;
  logic                   irq_reg;
  logic                   input_mode_reg;
  logic                   pullup_reg;
  logic                   fifo_in_valid;
  logic [FIFO_W-1:0]      fifo_in_data;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic [FIFO_W-1:0]      fifo_out_data;
  logic                   fifo_out_ready;

  // host pins enter the clock domain
  pin_filter #(
    .WIDTH (CTRL_SYNC_W),
    .RST   (CTRL_IDLE)
  ) u_ctrl_filter (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .pin_in   ({host_cs_n, host_read_strobe_n, host_write_strobe_n, host_addr_select}),
    .filt_reg (ctrl_f)
  );

  pin_filter #(
    .WIDTH (DATA_W),
    .RST   (DATA_RST)
  ) u_data_filter (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .pin_in   (host_data_in),
    .filt_reg (data_f)
  );

  assign cs_n_f = ctrl_f[3];
  assign rd_n_f = ctrl_f[2];
  assign wr_n_f = ctrl_f[1];
  assign addr_f = ctrl_f[0];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_n_q_reg <= 1'b1;
      wr_n_q_reg <= 1'b1;
    end else begin
      rd_n_q_reg <= rd_n_f;
      wr_n_q_reg <= wr_n_f;
    end
  end

  // strobe falling edges count only when enabled and selected
  assign wr_start = port_enable_bit & !cs_n_f & wr_n_q_reg & !wr_n_f
                    & (state_reg == CYC_IDLE);
  assign rd_start = port_enable_bit & !cs_n_f & rd_n_q_reg & !rd_n_f
                    & (state_reg == CYC_IDLE) & !wr_start;
  assign rd_end   = (state_reg == CYC_RD_HOLD) & (rd_n_f | cs_n_f);

  // sampling point: d clocks after the write strobe edge was seen
  assign sample_now = (wr_start && write_sample_delay == DELAY_CNT_RST)
                    | (state_reg == CYC_WR_WAIT && delay_cnt_reg == write_sample_delay);
  // a zero delay samples in the start cycle, before wr_addr_reg has caught the select
  assign push_addr    = wr_start ? addr_f : wr_addr_reg;
  assign host_push    = sample_now & fifo_in_ready;
  assign host_overrun = sample_now & !fifo_in_ready;
  assign host_pop      = rd_start & (addr_f == ADDR_DATA) & fifo_out_valid;
  assign host_underrun = rd_start & (addr_f == ADDR_DATA) & !fifo_out_valid;

  // host cycle tracker
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CYC_IDLE: begin
        if (wr_start) begin
          state_next = (write_sample_delay == DELAY_CNT_RST) ? CYC_WR_HOLD : CYC_WR_WAIT;
        end else if (rd_start) begin
          state_next = CYC_RD_HOLD;
        end
      end
      CYC_WR_WAIT: begin
        if (sample_now) begin
          state_next = CYC_WR_HOLD;
        end
      end
      CYC_WR_HOLD: begin
        if (wr_n_f | cs_n_f) begin
          state_next = CYC_IDLE;
        end
      end
      CYC_RD_HOLD: begin
        if (rd_end) begin
          state_next = CYC_IDLE;
        end
      end
      default: begin
        state_next = CYC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= CYC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      delay_cnt_reg <= DELAY_CNT_RST;
      wr_addr_reg   <= ADDR_DATA;
    end else if (wr_start) begin
      delay_cnt_reg <= DELAY_CNT_RST + 1'b1;
      wr_addr_reg   <= addr_f;
    end else if (state_reg == CYC_WR_WAIT) begin
      delay_cnt_reg <= delay_cnt_reg + 1'b1;
    end
  end

  // read data and bus drive
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_data_reg   <= DATA_RST;
      last_byte_reg <= DATA_RST;
    end else if (rd_start) begin
      if (addr_f == ADDR_STATUS) begin
        rd_data_reg <= {busy_reg, status_reg};
      end else if (fifo_out_valid) begin
        rd_data_reg   <= fifo_out_data;
        last_byte_reg <= fifo_out_data;
      end else begin
        rd_data_reg <= last_byte_reg;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      oe_n_reg <= 1'b1;
    end else begin
      oe_n_reg <= (state_next != CYC_RD_HOLD);
    end
  end

  // processing busy flag; hardware set wins over software clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busy_reg          <= BUSY_RST;
      clear_pending_reg <= 1'b0;
    end else begin
      if (host_push && push_addr == ADDR_STATUS) begin
        busy_reg          <= 1'b1;
        clear_pending_reg <= 1'b0;
      end else if (busy_set) begin
        busy_reg          <= 1'b1;
        clear_pending_reg <= 1'b0;
      end else if ((busy_clear || clear_pending_reg)
                   && (!service_by_channel || channel_peer_ready)) begin
        busy_reg          <= 1'b0;
        clear_pending_reg <= 1'b0;
      end else if (busy_clear) begin
        clear_pending_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      over_under_reg <= OVER_UNDER_RST;
    end else if (host_overrun || host_underrun) begin
      over_under_reg <= 1'b1;
    end else if (over_under_clear) begin
      over_under_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status_reg <= STATUS_RST;
    end else if (host_status_wr) begin
      status_reg <= host_status_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      empty_reg <= EMPTY_RST;
    end else begin
      empty_reg <= !fifo_out_valid;
    end
  end

  // ready for host: set when a byte waits, dropped at the end of a host read
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ready_reg <= READY_RST;
    end else if (rd_end) begin
      ready_reg <= 1'b0;
    end else if (fifo_out_valid && dir_to_host && state_reg != CYC_RD_HOLD) begin
      ready_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= port_global_irq_enable
                 & ((busy_irq_enable & busy_reg)
                    | (over_under_irq_enable & over_under_reg));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      input_mode_reg <= 1'b0;
      pullup_reg     <= 1'b1;
    end else begin
      input_mode_reg <= port_enable_bit;
      pullup_reg     <= !port_enable_bit;
    end
  end

  // fifo sharing: host accesses take the slot, device side stalls
  assign fifo_in_valid  = host_push | (dir_to_host & dev_in_valid & !sample_now);
  assign fifo_in_data   = sample_now ? data_f : dev_in_data;
  assign dev_in_ready   = dir_to_host & fifo_in_ready & !sample_now;
  assign fifo_out_ready = host_pop | (!dir_to_host & dev_out_ready & !rd_start);
  assign dev_out_valid  = !dir_to_host & fifo_out_valid & !rd_start;
  assign dev_out_data   = fifo_out_data;

  byte_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (fifo_in_valid),
    .in_data   (fifo_in_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_out_ready)
  );

  assign host_data_out        = rd_data_reg;
  assign host_data_oe_n       = oe_n_reg;
  assign pin_input_mode       = input_mode_reg;
  assign pin_pullup_on        = pullup_reg;
  assign fifo_empty_flag      = empty_reg;
  assign processing_busy_flag = busy_reg;
  assign over_under_flag      = over_under_reg;
  assign host_data_ready_flag = ready_reg;
  assign host_status_value    = status_reg;
  assign irq                  = irq_reg;

endmodule : parallel_slave_port

`default_nettype wire

// ==== verification/pslave_checker.sv ====
/*
  concurrent checks on the parallel slave port's top-level ports.
  assumes one ref_clk domain, synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none

module pslave_checker
  import pslave_pkg::*;
(
  // clock and reset
  input wire logic                ref_clk,
  input wire logic                reset,
  // host side
  input wire logic                host_cs_n,
  input wire logic                host_data_oe_n,
  input wire logic                pin_input_mode,
  input wire logic                pin_pullup_on,
  // control and commands
  input wire logic                port_enable_bit,
  input wire logic                busy_irq_enable,
  input wire logic                over_under_irq_enable,
  input wire logic                port_global_irq_enable,
  input wire logic                service_by_channel,
  input wire logic                channel_peer_ready,
  input wire logic                busy_set,
  input wire logic                busy_clear,
  input wire logic                host_status_wr,
  input wire logic [STATUS_W-1:0] host_status_wdata,
  // status
  input wire logic                processing_busy_flag,
  input wire logic                over_under_flag,
  input wire logic                over_under_clear,
  input wire logic                fifo_empty_flag,
  input wire logic [STATUS_W-1:0] host_status_value,
  input wire logic                irq,
  // device streams
  input wire logic                dev_in_valid,
  input wire logic                dev_in_ready,
  input wire logic                dev_out_ready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  pin_mode_a: assert property (!$past(reset) |-> pin_input_mode == $past(port_enable_bit))
    else $error("pin direction does not follow the enable bit");
  pullup_off_a: assert property (pin_pullup_on != pin_input_mode)
    else $error("pull-ups on while pins are inputs");
  irq_level_a: assert property (!$past(reset) |-> irq == $past(port_global_irq_enable
    && ((busy_irq_enable && processing_busy_flag) || (over_under_irq_enable && over_under_flag))))
    else $error("interrupt request does not match enabled flags");
  ou_sticky_a: assert property (over_under_flag && !over_under_clear |=> over_under_flag)
    else $error("overrun flag dropped without software clear");
  status_load_a: assert property (host_status_wr |=> host_status_value == $past(host_status_wdata))
    else $error("host status value not loaded");
  busy_release_a: assert property (host_cs_n [*4] ##0 (busy_clear && !service_by_channel
    && !busy_set) |=> !processing_busy_flag)
    else $error("busy flag not cleared by software");
  chan_hold_a: assert property (service_by_channel && !channel_peer_ready
    && processing_busy_flag |=> processing_busy_flag)
    else $error("busy cleared before channel peer ready");
  empty_track_a: assert property (host_cs_n [*4] ##0 (dev_in_valid && dev_in_ready
    && !dev_out_ready) ##1 !dev_out_ready |-> ##1 !fifo_empty_flag)
    else $error("empty flag still set after a byte entered");
  idle_bus_a: assert property (host_cs_n [*7] |-> host_data_oe_n)
    else $error("data bus driven without chip select");

  cover property (over_under_flag && irq);
  cover property (processing_busy_flag && !host_data_oe_n);
  cover property ($fell(fifo_empty_flag));
endmodule : pslave_checker

bind parallel_slave_port pslave_checker chk_u (.*);

`default_nettype wire

// ==== verification/host_model.sv ====
/*
  host processor model on the port's asynchronous read/write bus.
  assumes a read is answered by output enable low within a few clocks.
*/
`timescale 1ns/100ps
`default_nettype none

module host_model (
  // clock
  input  wire logic       ref_clk,
  // host pins
  output var  logic       cs_n,
  output var  logic       rd_n,
  output var  logic       wr_n,
  output var  logic       addr,
  output var  logic [7:0] wdata,
  // port answer
  input  wire logic [7:0] rdata,
  input  wire logic       oe_n
);
  initial begin
    cs_n  = 1'b1;
    rd_n  = 1'b1;
    wr_n  = 1'b1;
    addr  = 1'b0;
    wdata = 8'h00;
  end

  // strobe held past the latest sample point
  task automatic write_cycle(input logic sel, input logic a, input logic [7:0] d);
    @(posedge ref_clk);
    cs_n  <= ~sel;
    addr  <= a;
    wdata <= d;
    wr_n  <= 1'b0;
    repeat (14) @(posedge ref_clk);
    cs_n  <= 1'b1;
    wr_n  <= 1'b1;
    wdata <= ~d;
    repeat (10) @(posedge ref_clk);
  endtask : write_cycle

  task automatic read_cycle(input logic a, output logic [7:0] q);
    int n;
    @(posedge ref_clk);
    cs_n <= 1'b0;
    addr <= a;
    rd_n <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (oe_n !== 1'b0 && n < 12);
    @(posedge ref_clk);
    q = rdata;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
  endtask : read_cycle
endmodule : host_model

`default_nettype wire

// ==== verification/testbench.sv ====
/*
  self-checking bench of the parallel slave port, a host model on its pins.
  assumes host model, checker and design are compiled with it.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import pslave_pkg::*;
  logic ref_clk, reset, port_enable_bit, busy_irq_enable, over_under_irq_enable;
  logic port_global_irq_enable, service_by_channel, dir_to_host, busy_set, busy_clear;
  logic over_under_clear, host_status_wr, channel_peer_ready, dev_in_valid, dev_out_ready;
  logic [DELAY_W-1:0]  write_sample_delay;
  logic [STATUS_W-1:0] host_status_wdata, host_status_value;
  logic [DATA_W-1:0]   dev_in_data, dev_out_data, host_data_out, q;
  logic host_data_oe_n, pin_input_mode, pin_pullup_on, fifo_empty_flag, processing_busy_flag;
  logic over_under_flag, host_data_ready_flag, irq, dev_in_ready, dev_out_valid;
  wire logic host_cs_n, host_read_strobe_n, host_write_strobe_n, host_addr_select;
  wire logic [DATA_W-1:0] host_data_in;
  int errors, checked;

  parallel_slave_port dut_u (.*);
  host_model host_u (.ref_clk, .cs_n(host_cs_n), .rd_n(host_read_strobe_n),
    .wr_n(host_write_strobe_n), .addr(host_addr_select), .wdata(host_data_in),
    .rdata(host_data_out), .oe_n(host_data_oe_n));

  always #20 ref_clk = ~ref_clk;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic pop(input logic [7:0] exp);
    chk("drain valid", 8'h01, dev_out_valid);
    chk("drain data", exp, dev_out_data);
    @(posedge ref_clk) dev_out_ready <= 1'b1;
    @(posedge ref_clk) dev_out_ready <= 1'b0;
    tick(1);
  endtask : pop

  task automatic t_enable();
    chk("empty at reset", 8'h01, fifo_empty_flag);
    chk("oe_n at reset", 8'h01, host_data_oe_n);
    host_u.write_cycle(1'b1, ADDR_STATUS, 8'h11);
    chk("busy while disabled", 8'h00, processing_busy_flag);
    @(posedge ref_clk) port_enable_bit <= 1'b1;
    tick(2);
    chk("pin input", 8'h01, pin_input_mode);
    chk("pull-up", 8'h00, pin_pullup_on);
    host_u.write_cycle(1'b0, ADDR_STATUS, 8'h22);
    chk("busy unselected", 8'h00, processing_busy_flag);
    chk("empty unselected", 8'h01, fifo_empty_flag);
  endtask : t_enable

  task automatic t_status();
    @(posedge ref_clk) host_status_wr <= 1'b1;
    host_status_wdata <= 7'h5A;
    @(posedge ref_clk) host_status_wr <= 1'b0;
    host_u.read_cycle(ADDR_STATUS, q);
    chk("status idle", 8'h5A, q);
    @(posedge ref_clk) write_sample_delay <= 3'h3;
    host_u.write_cycle(1'b1, ADDR_STATUS, 8'hA5);
    chk("busy after write", 8'h01, processing_busy_flag);
    @(posedge ref_clk) busy_irq_enable <= 1'b1;
    port_global_irq_enable <= 1'b1;
    tick(2);
    chk("busy irq", 8'h01, irq);
    host_u.read_cycle(ADDR_STATUS, q);
    chk("status busy", 8'hDA, q);
    pop(8'hA5);
    @(posedge ref_clk) busy_clear <= 1'b1;
    @(posedge ref_clk) busy_clear <= 1'b0;
    tick(2);
    chk("busy cleared", 8'h00, processing_busy_flag);
    host_u.read_cycle(ADDR_STATUS, q);
    chk("status done", 8'h5A, q);
  endtask : t_status

  task automatic t_delay();
    for (int d = 0; d < 8; d++) begin
      @(posedge ref_clk) write_sample_delay <= 3'(d);
      host_u.write_cycle(1'b1, ADDR_DATA, 8'h30 + 8'(d));
      pop(8'h30 + 8'(d));
      chk("no busy on data", 8'h00, processing_busy_flag);
    end
  endtask : t_delay

  task automatic t_overrun();
    for (int i = 0; i < 16; i++) host_u.write_cycle(1'b1, ADDR_DATA, 8'h40 + 8'(i));
    chk("flag before full", 8'h00, over_under_flag);
    host_u.write_cycle(1'b1, ADDR_DATA, 8'hEE);
    chk("overrun flag", 8'h01, over_under_flag);
    @(posedge ref_clk) over_under_irq_enable <= 1'b1;
    tick(3);
    chk("overrun irq", 8'h01, irq);
    for (int i = 0; i < 16; i++) pop(8'h40 + 8'(i));
    chk("no extra byte", 8'h00, dev_out_valid);
    chk("empty drained", 8'h01, fifo_empty_flag);
    chk("flag sticky", 8'h01, over_under_flag);
    @(posedge ref_clk) over_under_clear <= 1'b1;
    @(posedge ref_clk) over_under_clear <= 1'b0;
    tick(2);
    chk("flag cleared", 8'h00, over_under_flag);
  endtask : t_overrun

  task automatic t_underrun();
    @(posedge ref_clk) dir_to_host <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk) dev_in_valid <= 1'b1;
      dev_in_data <= i ? 8'hC3 : 8'h3C;
    end
    @(posedge ref_clk) dev_in_valid <= 1'b0;
    tick(3);
    chk("ready flag", 8'h01, host_data_ready_flag);
    host_u.read_cycle(ADDR_DATA, q);
    chk("first read", 8'h3C, q);
    host_u.read_cycle(ADDR_DATA, q);
    chk("second read", 8'hC3, q);
    chk("empty polled", 8'h01, fifo_empty_flag);
    chk("ready cleared", 8'h00, host_data_ready_flag);
    host_u.read_cycle(ADDR_DATA, q);
    chk("underrun data", 8'hC3, q);
    chk("underrun flag", 8'h01, over_under_flag);
    @(posedge ref_clk) over_under_clear <= 1'b1;
    dir_to_host <= 1'b0;
    @(posedge ref_clk) over_under_clear <= 1'b0;
  endtask : t_underrun

  task automatic t_channel();
    @(posedge ref_clk) service_by_channel <= 1'b1;
    host_u.write_cycle(1'b1, ADDR_STATUS, 8'h77);
    @(posedge ref_clk) busy_clear <= 1'b1;
    @(posedge ref_clk) busy_clear <= 1'b0;
    tick(4);
    chk("busy held", 8'h01, processing_busy_flag);
    @(posedge ref_clk) channel_peer_ready <= 1'b1;
    tick(3);
    chk("busy released", 8'h00, processing_busy_flag);
    pop(8'h77);
  endtask : t_channel

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  initial begin
    {ref_clk, port_enable_bit, busy_irq_enable, over_under_irq_enable} = '0;
    {port_global_irq_enable, service_by_channel, dir_to_host, busy_set, busy_clear} = '0;
    {over_under_clear, host_status_wr, channel_peer_ready, dev_in_valid, dev_out_ready} = '0;
    {write_sample_delay, host_status_wdata, dev_in_data} = '0;
    {errors, checked} = '0;
    reset = 1'b1;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    tick(2);
    t_enable();
    t_status();
    t_delay();
    t_overrun();
    t_underrun();
    t_channel();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    wrap_up();
  end
endmodule : testbench

`default_nettype wire
